// ### logic/zss_pkg.sv
// Constants and types shared by the zone set selector.
// Assumes a single 25 MHz clock domain.
package zss_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int SETTLE_STEP_MS = 30;
  localparam int SETTLE_STEP_CYC = (CLK_HZ / 1000) * SETTLE_STEP_MS;
  // ---------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------
  localparam int MAX_SETS = 6;
  localparam int SEL_W = 3;
  localparam int NUM_WARN = 2;
  localparam logic [2:0] ACTIVE_RST = 3'h0;
  localparam logic [3:0] STEPS_MIN = 4'h1;
  typedef enum {ZSS_RUN, ZSS_SETTLE, ZSS_FAULT} zss_state_e;
endpackage

// ### logic/zss_top.sv
// Zone set selector: picks the active zone set from the select pins.
// Assumes detection flags and configuration are synchronous to clk and
// held steady by the surrounding logic; select pins are synchronised here.
`timescale 1ns/1ns
module zss_top
  import zss_pkg::*;
#(
  parameter int STEP_CYC = SETTLE_STEP_CYC,
  parameter int NSETS_MAX = MAX_SETS
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] zone_select_input,
  input wire logic [2:0] cfg_num_sets,
  input wire logic [3:0] cfg_delay_steps,
  input wire logic [SEL_W*MAX_SETS-1:0] cfg_codes,
  input wire logic [MAX_SETS-1:0] safety_zone_hit,
  input wire logic [NUM_WARN*MAX_SETS-1:0] warning_zone_hit,
  output logic [1:0] protective_output_pair,
  output logic [NUM_WARN-1:0] warning_zone_out,
  output logic [MAX_SETS-1:0] active_onehot,
  output logic switching,
  output logic fault,
  output logic cfg_error
);
  // Counters must reach twice the longest settle window without wrapping.
  localparam int CNT_W = $clog2(2 * STEP_CYC * 16);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (STEP_CYC < 1 || STEP_CYC > 1000000 || NSETS_MAX != MAX_SETS)
  begin : g_bad_param
    $error("zss_top: unsupported parameter values");
  end

  // ---------------------------------------------------------------
  // Code helpers
  // ---------------------------------------------------------------
  // Index of the set whose code matches, or MAX_SETS when none does.
  function automatic logic [2:0] code_lookup(
    input logic [2:0] code,
    input logic [SEL_W*MAX_SETS-1:0] codes,
    input logic [2:0] nsets,
    input logic [2:0] mask
  );
    logic [2:0] hit;
    hit = 3'(MAX_SETS);
    for (int i = MAX_SETS - 1; i >= 0; i--)
    begin
      if (3'(i) < nsets && (codes[i*SEL_W +: SEL_W] & mask) == (code & mask))
      begin
        hit = 3'(i);
      end
    end
    return hit;
  endfunction

  function automatic logic two_apart(
    input logic [2:0] a,
    input logic [2:0] b
  );
    logic [2:0] x;
    x = a ^ b;
    return (x[0] & x[1]) | (x[0] & x[2]) | (x[1] & x[2]);
  endfunction

  // Pins in use: two sets need two pins, more need all three.
  logic [2:0] pin_mask;
  assign pin_mask = (cfg_num_sets > 3'h2) ? 3'h7 : 3'h3;

  // Configuration is refused when any pair of codes in use is too close.
  logic codes_bad;
  always_comb
  begin
    codes_bad = 1'b0;
    for (int i = 0; i < MAX_SETS; i++)
    begin
      for (int j = i + 1; j < MAX_SETS; j++)
      begin
        if (3'(j) < cfg_num_sets &&
            !two_apart(cfg_codes[i*SEL_W +: SEL_W] & pin_mask,
                       cfg_codes[j*SEL_W +: SEL_W] & pin_mask))
        begin
          codes_bad = 1'b1;
        end
      end
    end
    if (cfg_num_sets == 3'h0 || cfg_num_sets > 3'(MAX_SETS))
    begin
      codes_bad = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Input synchroniser
  // ---------------------------------------------------------------
  logic [2:0] sel_meta_q;
  logic [2:0] sel_q;
  logic [2:0] sel_prev_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sel_meta_q <= 3'h0;
      sel_q <= 3'h0;
      sel_prev_q <= 3'h0;
    end
    else
    begin
      sel_meta_q <= zone_select_input;
      sel_q <= sel_meta_q;
      sel_prev_q <= sel_q;
    end
  end

  logic multi;
  logic [2:0] cur_hit;
  logic [3:0] steps;
  logic [CNT_W-1:0] limit;
  assign multi = cfg_num_sets > 3'h1;
  assign cur_hit = code_lookup(sel_q, cfg_codes, cfg_num_sets, pin_mask);
  assign steps = (cfg_delay_steps < STEPS_MIN) ? STEPS_MIN : cfg_delay_steps;
  assign limit = CNT_W'(STEP_CYC) * CNT_W'(steps);

  // ---------------------------------------------------------------
  // Changeover control
  // ---------------------------------------------------------------
  zss_state_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] stable_q;
  logic [2:0] active_q;
  // The outer window counts from the first change; the stable count
  // restarts on every bounce, so a chattering input ends in fault.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ZSS_RUN;
      cnt_q <= '0;
      stable_q <= '0;
      active_q <= ACTIVE_RST;
    end
    else
    begin
      case (state_q)
        ZSS_RUN:
        begin
          cnt_q <= '0;
          stable_q <= '0;
          if (!multi)
          begin
            active_q <= ACTIVE_RST;
          end
          else if (sel_q != sel_prev_q)
          begin
            state_q <= ZSS_SETTLE;
          end
        end
        ZSS_SETTLE:
        begin
          cnt_q <= cnt_q + CNT_W'(1);
          stable_q <= (sel_q != sel_prev_q) ? '0 : stable_q + CNT_W'(1);
          if (stable_q + CNT_W'(1) >= limit && sel_q == sel_prev_q)
          begin
            if (cur_hit == 3'(MAX_SETS))
            begin
              state_q <= ZSS_FAULT;
            end
            else
            begin
              active_q <= cur_hit;
              state_q <= ZSS_RUN;
            end
          end
          else if (cnt_q + CNT_W'(1) >= limit + limit)
          begin
            state_q <= ZSS_FAULT;
          end
        end
        ZSS_FAULT:
        begin
          state_q <= ZSS_FAULT;
        end
        default:
        begin
          state_q <= ZSS_FAULT;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Output drive
  // ---------------------------------------------------------------
  // During settling the old set still watches its zone, but the newly
  // selected safety zone cannot trip the outputs yet.
  logic sz_hit;
  logic [NUM_WARN-1:0] wz_hit;
  assign sz_hit = safety_zone_hit[active_q];
  assign wz_hit = warning_zone_hit[active_q*NUM_WARN +: NUM_WARN];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      protective_output_pair <= 2'h0;
      warning_zone_out <= '0;
      active_onehot <= '0;
      switching <= 1'b0;
      fault <= 1'b0;
      cfg_error <= 1'b0;
    end
    else
    begin
      if (state_q == ZSS_FAULT || sz_hit || codes_bad)
      begin
        protective_output_pair <= 2'h0;
      end
      else
      begin
        protective_output_pair <= 2'h3;
      end
      warning_zone_out <= (state_q == ZSS_FAULT) ? '0 : wz_hit;
      active_onehot <= '0;
      active_onehot[active_q] <= (state_q != ZSS_FAULT);
      switching <= state_q == ZSS_SETTLE;
      fault <= state_q == ZSS_FAULT;
      cfg_error <= codes_bad && multi;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_onehot_active: assert property (
    $onehot0(active_onehot)) else $error("more than one set active");
  a_sz_off: assert property (
    sz_hit |=> protective_output_pair == 2'h0)
    else $error("outputs on during safety violation");
  a_fault_off: assert property (
    fault |-> protective_output_pair == 2'h0)
    else $error("outputs on in fault");
  a_single_hold: assert property (
    !multi |=> active_q == ACTIVE_RST) else $error("single set moved");
  a_hold_settle: assert property (
    state_q == ZSS_SETTLE && sel_q != sel_prev_q |=> $stable(active_q))
    else $error("set changed while unstable");
  a_bad_code: assert property (
    state_q == ZSS_SETTLE && stable_q + CNT_W'(1) >= limit &&
    sel_q == sel_prev_q && cur_hit == 3'(MAX_SETS) |=> state_q == ZSS_FAULT)
    else $error("unknown code accepted");
  a_min_delay: assert property (
    state_q == ZSS_RUN && multi && sel_q != sel_prev_q |=>
    state_q == ZSS_SETTLE) else $error("change accepted without delay");
  a_fault_sticky: assert property (
    state_q == ZSS_FAULT |=> state_q == ZSS_FAULT)
    else $error("fault left");
  a_switching_flag: assert property (
    switching |-> $past(state_q) == ZSS_SETTLE)
    else $error("switching flag wrong");

  // A settled, known code must be taken on the very next edge.
  sequence s_settled;
    state_q == ZSS_SETTLE && sel_q == sel_prev_q &&
    stable_q + CNT_W'(1) >= limit && cur_hit != 3'(MAX_SETS);
  endsequence
  // The outer window has run out while still settling.
  sequence s_window_out;
    state_q == ZSS_SETTLE && cnt_q + CNT_W'(1) >= limit + limit;
  endsequence

  a_accept_code: assert property (
    s_settled |=> state_q == ZSS_RUN && active_q == $past(cur_hit))
    else $error("settled code not taken");
  a_window_end: assert property (
    s_window_out |=> state_q != ZSS_SETTLE)
    else $error("settle window overran");
  a_new_zone_masked: assert property (
    state_q == ZSS_SETTLE && !safety_zone_hit[active_q] && !codes_bad
    |=> protective_output_pair == 2'h3)
    else $error("new safety zone acted during changeover");
  a_run_one_set: assert property (
    state_q == ZSS_RUN |=> $onehot(active_onehot))
    else $error("not exactly one set active");
endmodule // zss_top

// ### tb/zss_ctrl_model.sv
// Partner model: the machine controller that drives the zone select pins.
// Assumes the bench calls its tasks; pins move 1 ns after clk rises.
`timescale 1ns/1ns
module zss_ctrl_model
(
  input wire logic clk,
  output logic [2:0] sel
);
  // Pins start at the code of the first set.
  initial sel = 3'h0;

  // Moves to a new code; callers keep to two-bit steps for safety.
  task automatic go(input logic [2:0] code);
    @(posedge clk);
    #1 sel = code;
  endtask

  // Flips all pins faster than the settle time; only a fault test asks.
  task automatic chatter(input int n);
    repeat (n)
    begin
      repeat (2) @(posedge clk);
      #1 sel = ~sel;
    end
  endtask
endmodule // zss_ctrl_model

// ### tb/tb.sv
// Self-checking bench for the zone set selector.
// Assumes STEP_CYC of 4 so one settle step lasts four clocks.
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("FAIL %0t got %0h exp %0h", $time, a, b); end end
module tb;
  logic clk;
  logic rstn;
  logic [2:0] sel;
  logic [2:0] nsets;
  logic [3:0] steps;
  logic [17:0] codes;
  logic [5:0] sz;
  logic [11:0] wz;
  logic [1:0] pair;
  logic [1:0] wout;
  logic [5:0] act;
  logic sw, flt, cerr;
  int mismatches = 0;
  int checked = 0;

  // ----------------------------------------------------------------
  // Clock, design and controller
  // ----------------------------------------------------------------
  always #20 clk = ~clk;
  zss_top #(.STEP_CYC(4)) i_dut (.clk(clk), .rstn(rstn),
    .zone_select_input(sel), .cfg_num_sets(nsets),
    .cfg_delay_steps(steps), .cfg_codes(codes), .safety_zone_hit(sz),
    .warning_zone_hit(wz), .protective_output_pair(pair),
    .warning_zone_out(wout), .active_onehot(act), .switching(sw),
    .fault(flt), .cfg_error(cerr));
  zss_ctrl_model i_ctrl (.clk(clk), .sel(sel));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Bounded wait: a hung selector must not hang the run.
  task automatic wait_act(input logic [5:0] exp);
    int n;
    n = 0;
    while (act !== exp && n < 100)
    begin
      @(posedge clk);
      #2 n++;
    end
    if (act !== exp)
    begin
      mismatches++;
      $display("FAIL %0t wait for active set ran out", $time);
      finish_test();
    end
  endtask

  // Holds reset four clocks; the fault flag only clears here.
  task automatic do_reset;
    rstn = 0;
    repeat (4) @(posedge clk);
    #1 rstn = 1;
    repeat (2) @(posedge clk);
    #2 `CHK(act, 6'h01)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Old set governs while settling; new set's intrusion then counts.
  task automatic t_switch;
    sz = 6'h02;
    wz = 12'h030;
    i_ctrl.go(3'h3);
    repeat (5) @(posedge clk);
    #2 `CHK(sw, 1'b1)
    `CHK(act, 6'h01)
    `CHK(pair, 2'h3)
    wait_act(6'h02);
    `CHK(pair, 2'h0)
    `CHK(sw, 1'b0)
    i_ctrl.go(3'h5);
    wait_act(6'h04);
    `CHK(pair, 2'h3)
    `CHK(wout, 2'h3)
    `CHK(cerr, 1'b0)
    $display("switch test done");
  endtask

  // A quick second change restarts the stability count.
  task automatic t_bounce;
    i_ctrl.go(3'h0);
    i_ctrl.go(3'h3);
    repeat (7) @(posedge clk);
    #2 `CHK(act, 6'h04)
    wait_act(6'h02);
    `CHK(flt, 1'b0)
    $display("bounce test done");
  endtask

  // Unknown settled code, then 12 flips of chatter, both end in fault.
  task automatic t_faults;
    wz = 12'hFFF;
    i_ctrl.go(3'h6);
    wait_act(6'h00);
    `CHK(flt, 1'b1)
    `CHK(wout, 2'h0)
    i_ctrl.go(3'h0);
    do_reset();
    i_ctrl.chatter(12);
    `CHK(flt, 1'b1)
    do_reset();
    $display("fault test done");
  endtask

  // One set ignores the pins; close codes raise a config error.
  task automatic t_config;
    nsets = 3'h1;
    wz = 12'hFFE;
    i_ctrl.go(3'h3);
    repeat (15) @(posedge clk);
    #2 `CHK(act, 6'h01)
    `CHK(sw, 1'b0)
    `CHK(wout, 2'h2)
    `CHK(pair, 2'h3)
    nsets = 3'h3;
    codes = 18'h00159;
    repeat (3) @(posedge clk);
    #2 `CHK(cerr, 1'b1)
    `CHK(pair, 2'h0)
    $display("config test done");
  endtask

  // Two settle steps double the wait; zero steps act as one step.
  task automatic t_delay;
    steps = 4'h2;
    i_ctrl.go(3'h5);
    repeat (11) @(posedge clk);
    #2 `CHK(act, 6'h02)
    wait_act(6'h04);
    `CHK(sw, 1'b0)
    steps = 4'h0;
    i_ctrl.go(3'h3);
    repeat (7) @(posedge clk);
    #2 `CHK(act, 6'h04)
    wait_act(6'h02);
    steps = 4'h1;
    $display("delay test done");
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial
  begin
    clk = 1'b0;
    nsets = 3'h3;
    steps = 4'h1;
    codes = 18'h00158;
    sz = 6'h00;
    wz = 12'h000;
    do_reset();
    t_switch();
    t_bounce();
    t_delay();
    t_faults();
    t_config();
    finish_test();
  end
endmodule // tb
